// file: lane_status_pkg.sv
// Purpose: Shared constants and carriers for the lane status flag bank.
// Assumes: AHB-Lite register port, 32-bit data, one aligned word per register.
// Notes: Register offsets are word indexes; the byte address is four times the index.
`default_nettype none

package lane_status_pkg;

  // ---------------------------------------------------------------
  // Register indexes (byte address = index * 4)
  // ---------------------------------------------------------------
  localparam logic [11:0] LINK_PAGE_IDX = 12'h300;
  localparam logic [11:0] THRESH_IDX = 12'h301;
  localparam logic [11:0] LANE6_STATE_IDX = 12'h4b6;
  localparam logic [11:0] LANE7_STATE_IDX = 12'h4b7;
  localparam logic [11:0] IRQ_STATUS_IDX = 12'h4c0;
  localparam logic [11:0] IRQ_MASK_IDX = 12'h4c1;

  // ---------------------------------------------------------------
  // Field layout and reset values
  // ---------------------------------------------------------------
  localparam int NUM_LANES = 2;
  localparam int NUM_ERR = 3;
  localparam int PAGE_W = 1;
  localparam int CNT_W = 8;
  localparam int FLAG_W = 8;
  localparam int IRQ_W = NUM_LANES * FLAG_W;
  localparam int PAGE_CLR_BIT = 7;
  localparam int ERR_LSB = 5;
  localparam logic [PAGE_W-1:0] PAGE_RST = 1'h0;
  localparam logic [CNT_W-1:0] THRESH_RST = 8'hff;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  // One-cycle error events from a lane receiver
  typedef struct packed {
    logic bad_disparity;
    logic not_in_table;
    logic unexpected_k;
  } lane_err_t;

  // Live lane state levels from a lane receiver
  typedef struct packed {
    logic deskew_ok;
    logic initial_align_ok;
    logic config_sum_good;
    logic frame_lock;
    logic code_group_lock;
  } lane_state_t;

  // Status byte as software sees it, bit 7 first
  typedef struct packed {
    logic bad_disparity_flag;
    logic not_in_table_flag;
    logic unexpected_k_flag;
    logic deskew_ok;
    logic initial_align_ok;
    logic config_sum_good;
    logic frame_lock;
    logic code_group_lock;
  } lane_flags_t;

  // Address phase held over into the data phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [11:0] idx;
  } ahb_dph_t;

endpackage

`default_nettype wire

// file: serial_lane_status_flags.sv
// Purpose: Paged status flags of receive lanes 6 and 7, read over AHB-Lite.
// Assumes: Lane receivers run on clk; error inputs are one-cycle pulses.
// Notes: Zero wait states; error counters saturate and clear only by reset or command.
//
// Contract
// - Lane 6 and 7 bit 7: disparity count reached threshold
// - Bit 6: not-in-table count at threshold
// - Bit 5: unexpected control count at threshold
// - Bit 4: deskew succeeded
// - Bit 3: initial lane alignment held
// - Bit 2: configuration checksum correct
// - Bit 1: frame synchronization held
// - Bit 0: code-group synchronization held
// - Flags show only the selected link
// - Error flag is count at or above threshold
//
// The AHB-Lite slave port was chosen for this implementation.
`default_nettype none

module serial_lane_status_flags #(
  parameter int NUM_LINKS = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire lane_status_pkg::lane_err_t [NUM_LINKS-1:0][lane_status_pkg::NUM_LANES-1:0] lane_err,
  input wire lane_status_pkg::lane_state_t [NUM_LINKS-1:0][lane_status_pkg::NUM_LANES-1:0] lane_state,
  output logic irq
);
  import lane_status_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (v == CNT_MAX) ? v : v + 8'h01;
  endfunction

  // Count at or above threshold
  function automatic logic at_limit(input logic [CNT_W-1:0] cnt,
                                    input logic [CNT_W-1:0] lim);
    at_limit = (cnt >= lim);
  endfunction

  // Word index of a byte address, or an illegal marker if off the map
  function automatic logic [12:0] word_idx(input logic [31:0] a);
    if (a[31:14] != 18'h0 || a[1:0] != 2'h0) begin
      word_idx = {1'b1, 12'h0};
    end else begin
      word_idx = {1'b0, a[13:2]};
    end
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [NUM_LINKS-1:0][NUM_LANES-1:0][NUM_ERR-1:0][CNT_W-1:0] cnt_ff, nxt_cnt;
  lane_flags_t [NUM_LINKS-1:0][NUM_LANES-1:0] flags_ff, nxt_flags;
  logic [PAGE_W-1:0] page_ff, nxt_page;
  logic [CNT_W-1:0] thresh_ff, nxt_thresh;
  logic [IRQ_W-1:0] irq_stat_ff, nxt_irq_stat;
  logic [IRQ_W-1:0] irq_mask_ff, nxt_irq_mask;
  logic irq_ff, nxt_irq;
  ahb_dph_t dph_ff, nxt_dph;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic hreadyout_ff;
  logic hresp_ff;

  logic wr_en;
  logic clr_cnt;
  logic [IRQ_W-1:0] ev;
  logic [12:0] aidx;
  logic [PAGE_W-1:0] rd_page;
  lane_flags_t rd_flags;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_flags = flags_ff;
    nxt_page = page_ff;
    nxt_thresh = thresh_ff;
    nxt_irq_stat = irq_stat_ff;
    nxt_irq_mask = irq_mask_ff;
    nxt_dph = dph_ff;
    nxt_hrdata = 32'h0;
    ev = '0;
    rd_page = '0;
    rd_flags = '0;
    aidx = word_idx(haddr);

    // Data phase: writes land at its end; flag registers ignore writes
    wr_en = dph_ff.valid && dph_ff.write;
    clr_cnt = 1'b0;
    if (wr_en) begin
      unique case (dph_ff.idx)
        LINK_PAGE_IDX: begin
          nxt_page = hwdata[PAGE_W-1:0];
          clr_cnt = hwdata[PAGE_CLR_BIT];
        end
        THRESH_IDX: nxt_thresh = hwdata[CNT_W-1:0];
        IRQ_MASK_IDX: nxt_irq_mask = hwdata[IRQ_W-1:0];
        IRQ_STATUS_IDX: nxt_irq_stat = irq_stat_ff & ~hwdata[IRQ_W-1:0];
        default: ;
      endcase
    end

    // Error counters saturate so a flag cannot fall back by wrap-around
    for (int l = 0; l < NUM_LINKS; l++) begin
      for (int n = 0; n < NUM_LANES; n++) begin
        for (int t = 0; t < NUM_ERR; t++) begin
          if (clr_cnt) begin
            nxt_cnt[l][n][t] = '0;
          end else if (lane_err[l][n][t]) begin
            nxt_cnt[l][n][t] = sat_inc(cnt_ff[l][n][t]);
          end
        end
      end
    end

    // Flags: one cycle behind the counters and state inputs
    for (int l = 0; l < NUM_LINKS; l++) begin
      for (int n = 0; n < NUM_LANES; n++) begin
        nxt_flags[l][n].bad_disparity_flag = at_limit(cnt_ff[l][n][2], thresh_ff);
        nxt_flags[l][n].not_in_table_flag = at_limit(cnt_ff[l][n][1], thresh_ff);
        nxt_flags[l][n].unexpected_k_flag = at_limit(cnt_ff[l][n][0], thresh_ff);
        nxt_flags[l][n].deskew_ok = lane_state[l][n].deskew_ok;
        nxt_flags[l][n].initial_align_ok = lane_state[l][n].initial_align_ok;
        nxt_flags[l][n].config_sum_good = lane_state[l][n].config_sum_good;
        nxt_flags[l][n].frame_lock = lane_state[l][n].frame_lock;
        nxt_flags[l][n].code_group_lock = lane_state[l][n].code_group_lock;
      end
    end

    // Events: an error flag rising or a good state falling, any link
    for (int n = 0; n < NUM_LANES; n++) begin
      for (int l = 0; l < NUM_LINKS; l++) begin
        for (int b = 0; b < FLAG_W; b++) begin
          if (b >= ERR_LSB) begin
            ev[n*FLAG_W+b] = ev[n*FLAG_W+b] | (nxt_flags[l][n][b] & ~flags_ff[l][n][b]);
          end else begin
            ev[n*FLAG_W+b] = ev[n*FLAG_W+b] | (flags_ff[l][n][b] & ~nxt_flags[l][n][b]);
          end
        end
      end
    end
    // Set wins over a clear in the same cycle
    nxt_irq_stat = nxt_irq_stat | ev;
    nxt_irq = |(nxt_irq_stat & nxt_irq_mask);

    // Address phase; read data built from next values so a read right
    // after a write sees the written value
    nxt_dph.valid = 1'b0;
    if (hsel && hready && htrans == HTRANS_NONSEQ) begin
      nxt_dph.valid = 1'b1;
      nxt_dph.write = hwrite;
      nxt_dph.idx = aidx[11:0];
      if (!hwrite && !aidx[12]) begin
        rd_page = nxt_page;
        if (32'(rd_page) < 32'(NUM_LINKS)) begin
          rd_flags = (aidx[11:0] == LANE6_STATE_IDX) ? nxt_flags[rd_page][0]
                                                     : nxt_flags[rd_page][1];
        end
        unique case (aidx[11:0])
          LINK_PAGE_IDX: nxt_hrdata = {{(32-PAGE_W){1'b0}}, nxt_page};
          THRESH_IDX: nxt_hrdata = {{(32-CNT_W){1'b0}}, nxt_thresh};
          LANE6_STATE_IDX: nxt_hrdata = {{(32-FLAG_W){1'b0}}, rd_flags};
          LANE7_STATE_IDX: nxt_hrdata = {{(32-FLAG_W){1'b0}}, rd_flags};
          IRQ_STATUS_IDX: nxt_hrdata = {{(32-IRQ_W){1'b0}}, nxt_irq_stat};
          IRQ_MASK_IDX: nxt_hrdata = {{(32-IRQ_W){1'b0}}, nxt_irq_mask};
          default: nxt_hrdata = 32'h0;
        endcase
      end
      if (aidx[12]) begin
        nxt_dph.idx = 12'h0;
        nxt_dph.write = 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= '0;
      flags_ff <= '0;
      page_ff <= PAGE_RST;
      thresh_ff <= THRESH_RST;
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
      irq_ff <= 1'b0;
      dph_ff <= '0;
      hrdata_ff <= 32'h0;
      hreadyout_ff <= 1'b1;
      hresp_ff <= HRESP_OKAY;
    end else begin
      cnt_ff <= nxt_cnt;
      flags_ff <= nxt_flags;
      page_ff <= nxt_page;
      thresh_ff <= nxt_thresh;
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
      irq_ff <= nxt_irq;
      dph_ff <= nxt_dph;
      hrdata_ff <= nxt_hrdata;
      hreadyout_ff <= 1'b1;
      hresp_ff <= HRESP_OKAY;
    end
  end

  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign hrdata = hrdata_ff;
  assign irq = irq_ff;

  // hsize is unused: only whole-word transfers are supported
  logic unused_size;
  assign unused_size = ^hsize;

endmodule

`default_nettype wire

// file: lane_status_asserts.sv
// Purpose: Port-level checks of the lane status flag bank.
// Assumes: Zero wait states; links 0 and 1 present.
// Notes: State checks fire only when both links agree, as the page is internal.
`default_nettype none
module lane_status_asserts #(
  parameter int NUM_LINKS = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire lane_status_pkg::lane_state_t
    [NUM_LINKS-1:0][lane_status_pkg::NUM_LANES-1:0] lane_state,
  input wire logic irq
);
  import lane_status_pkg::*;
  logic rd_tk;
  assign rd_tk = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // -----------------------------------------
  // Bus answer and status reads
  // -----------------------------------------
  ready_high_a: assert property (hreadyout == 1'b1) else $error("hreadyout low");
  resp_okay_a: assert property (hresp == HRESP_OKAY) else $error("hresp not okay");
  rdata_idle_a: assert property (!rd_tk |=> hrdata == 32'h0) else $error("hrdata not idle");
  unmapped_zero_a: assert property (
    rd_tk && haddr[31:14] != 18'h0 |=> hrdata == 32'h0) else $error("unmapped read not 0");
  status_width_a: assert property (
    rd_tk && haddr inside {32'h12d8, 32'h12dc} |=> hrdata[31:8] == 24'h0)
    else $error("status upper bits set");
  lane6_state_a: assert property (
    rd_tk && haddr == 32'h12d8 && lane_state[0][0] == lane_state[1][0]
    |=> hrdata[4:0] == $past(lane_state[0][0])) else $error("lane6 state bits wrong");
  lane7_state_a: assert property (
    rd_tk && haddr == 32'h12dc && lane_state[0][1] == lane_state[1][1]
    |=> hrdata[4:0] == $past(lane_state[0][1])) else $error("lane7 state bits wrong");
  irq_reset_a: assert property ($rose(rst_b) |-> irq == 1'b0) else $error("irq after reset");
endmodule
bind serial_lane_status_flags lane_status_asserts #(.NUM_LINKS(NUM_LINKS)) props (
  .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .lane_state(lane_state), .irq(irq));
`default_nettype wire

// file: lane_partner.sv
// Purpose: Lane receiver stand-in feeding error pulses and state levels.
// Assumes: Commanded by the bench through task calls, all on clk.
// Notes: Errors are one-cycle pulses; states hold until changed.
`default_nettype none
module lane_partner (
  input wire logic clk,
  output var lane_status_pkg::lane_err_t [1:0][lane_status_pkg::NUM_LANES-1:0] lane_err,
  output var lane_status_pkg::lane_state_t [1:0][lane_status_pkg::NUM_LANES-1:0] lane_state
);
  timeunit 1ns;
  timeprecision 1ns;
  import lane_status_pkg::*;
  initial begin
    lane_err = '0;
    lane_state = '0;
  end
  // Kind 0 disparity, 1 not in table, 2 unexpected control
  task automatic pulse(input int lk, ln, k);
    @(posedge clk);
    lane_err[lk][ln] <= lane_err_t'(3'h4 >> k);
    @(posedge clk);
    lane_err[lk][ln] <= '0;
    repeat (2) @(posedge clk);
  endtask
  task automatic state(input int lk, ln, input lane_state_t v);
    @(posedge clk);
    lane_state[lk][ln] <= v;
  endtask
endmodule
`default_nettype wire

// file: tb.sv
// Purpose: Self-checking bench for the lane status flag bank.
// Assumes: One slave, so hready is its own hreadyout.
// Notes: Expected values come from the bit layout, never from the design.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import lane_status_pkg::*;
  logic clk = 0, rst_b = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp, irq;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, exp;
  lane_err_t [1:0][NUM_LANES-1:0] lane_err;
  lane_state_t [1:0][NUM_LANES-1:0] lane_state;
  int bad_count = 0, n_checks = 0;
  always #20 clk = ~clk;
  assign hready = hreadyout;
  serial_lane_status_flags uut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .lane_err(lane_err),
    .lane_state(lane_state), .irq(irq));
  lane_partner peer (.clk(clk), .lane_err(lane_err), .lane_state(lane_state));
  // -----------------------------------------
  // Bus and compare tasks
  // -----------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, d);
    @(posedge clk);
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    hsel <= 1'b1;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdc(input string nm, input logic [31:0] a, exp);
    xfer(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask
  task automatic irqc(input logic e);
    repeat (2) @(posedge clk);
    chk("irq", {31'h0, irq}, {31'h0, e});
  endtask
  task automatic results();
    if (bad_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // -----------------------------------------
  // Scenarios
  // -----------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rdc("lane6 reset", 32'h12d8, 32'h0);
    rdc("threshold", 32'h0c04, 32'hff);
    xfer(1'b1, 32'h12dc, 32'hff);
    rdc("lane7 write", 32'h12dc, 32'h0);
    rdc("unmapped", 32'h4000, 32'h0);
    for (int i = 0; i < 5; i++) begin
      peer.state(0, 0, lane_state_t'(5'h1 << i));
      peer.state(0, 1, lane_state_t'(~(5'h1 << i)));
      rdc("lane6 state", 32'h12d8, 32'h1 << i);
      rdc("lane7 state", 32'h12dc, {27'h0, ~(5'h1 << i)});
    end
    peer.state(1, 0, lane_state_t'(5'h1b));
    xfer(1'b1, 32'h0c00, 32'h1);
    rdc("link1 lane6", 32'h12d8, 32'h1b);
    xfer(1'b1, 32'h0c00, 32'h0);
    peer.state(0, 0, lane_state_t'(5'h0));
    peer.state(0, 1, lane_state_t'(5'h0));
    xfer(1'b1, 32'h0c04, 32'h2);
    exp = 32'h0;
    for (int k = 0; k < 3; k++) begin
      peer.pulse(0, 0, k);
      rdc("below threshold", 32'h12d8, exp);
      peer.pulse(0, 0, k);
      exp[7-k] = 1'b1;
      rdc("at threshold", 32'h12d8, exp);
    end
    repeat (2) peer.pulse(0, 1, 0);
    rdc("lane7 disparity", 32'h12dc, 32'h80);
    xfer(1'b1, 32'h0c00, 32'h1);
    rdc("link1 lane7", 32'h12dc, 32'h0);
    xfer(1'b1, 32'h0c00, 32'h80);
    rdc("counters cleared", 32'h12d8, 32'h0);
    irqc(1'b0);
    xfer(1'b1, 32'h1304, 32'hffff);
    irqc(1'b1);
    xfer(1'b1, 32'h1300, 32'hffff);
    rdc("irq cleared", 32'h1300, 32'h0);
    irqc(1'b0);
    peer.state(0, 0, lane_state_t'(5'h10));
    peer.state(0, 0, lane_state_t'(5'h0));
    repeat (3) @(posedge clk);
    rdc("deskew fall", 32'h1300, 32'h10);
    irqc(1'b1);
    xfer(1'b1, 32'h1304, 32'hffef);
    irqc(1'b0);
    results();
  end
  // Whole run is under three hundred cycles; this leaves ample margin
  initial begin
    #400000;
    bad_count++;
    results();
  end
endmodule
`default_nettype wire
